/* core/adsq_clkgen.v */
`timescale 1ns/100ps
`include "adsq_consts.vh"
// conversion clock tick generator
module adsq_clkgen (
  clk,
  rst_n,
  run,
  use_rc,
  rc_tick,
  divider,
  tad_tick
);
  input wire clk;
  input wire rst_n;
  input wire run;
  input wire use_rc;
  input wire rc_tick;
  input wire [7:0] divider;
  output reg tad_tick;
  reg [7:0] cnt_reg;
  wire [7:0] div_eff;
  // reserved divider values are clamped so the period stays bounded
  assign div_eff = (divider > `ADSQ_DIV_MAX) ? `ADSQ_DIV_MAX : divider;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
      tad_tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 8'h00;
      tad_tick <= 1'b0;
    end else if (use_rc) begin
      cnt_reg <= 8'h00;
      tad_tick <= rc_tick;
    end else if (cnt_reg >= div_eff) begin
      cnt_reg <= 8'h00;
      tad_tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      tad_tick <= 1'b0;
    end
  end
endmodule // adsq_clkgen

/* core/adsq_consts.vh */
`ifndef ADSQ_CONSTS_VH
`define ADSQ_CONSTS_VH
// register indices on the plain port (3-bit address)
`define ADSQ_ADDR_CTRL1 3'h0
`define ADSQ_ADDR_CTRL2 3'h1
`define ADSQ_ADDR_CTRL3 3'h2
`define ADSQ_ADDR_INSEL 3'h3
`define ADSQ_ADDR_PIN_ANALOG_CONFIG 3'h4
`define ADSQ_ADDR_SCAN 3'h5
`define ADSQ_ADDR_BUFRD 3'h6
`define ADSQ_ADDR_BUFIX 3'h7
// control one fields
`define ADSQ_C1_ON 15
`define ADSQ_C1_FMT_LO 8
`define ADSQ_C1_TRIG_LO 5
`define ADSQ_C1_AUTO_SAMPLE_START 2
`define ADSQ_C1_SAMPLE_ENABLE 1
`define ADSQ_C1_DONE 0
`define ADSQ_C1_WMASK 16'hA3E7
// control two fields
`define ADSQ_C2_SCAN 10
`define ADSQ_C2_BUFFER_HALF_STATUS 7
`define ADSQ_C2_SEQUENCES_PER_INTERRUPT_LO 2
`define ADSQ_C2_SPLIT_BUFFER_MODE 1
`define ADSQ_C2_ALTERNATE_MUX_MODE 0
`define ADSQ_C2_WMASK 16'hE43F
// control three fields, input select mask and divider limit
`define ADSQ_C3_RC 15
`define ADSQ_C3_AUTO_SAMPLE_TIME_LO 8
`define ADSQ_C3_WMASK 16'h9FFF
`define ADSQ_INSEL_WMASK 16'h9F9F
`define ADSQ_DIV_MAX 8'h3F
// trigger sources
`define ADSQ_TRIG_SW 3'h0
`define ADSQ_TRIG_PIN 3'h1
`define ADSQ_TRIG_TMR_A 3'h2
`define ADSQ_TRIG_TMR_B 3'h4
`define ADSQ_TRIG_CTU 3'h6
`define ADSQ_TRIG_AUTO 3'h7
// input codes and conversion length
`define ADSQ_CH_LAST_PIN 5'h0C
`define ADSQ_CH_CORE 5'h0D
`define ADSQ_CH_HALF_BG 5'h0E
`define ADSQ_CH_BG 5'h0F
`define ADSQ_CH_CTU 5'h1F
`define ADSQ_CONV_TADS 5'h0C
`endif

/* core/adsq_seq_ctrl.v */
// Contract
// - scan enable steps mux A positive input
// - fill status shows half being filled
// - interrupt every field-plus-one sequences
// - buffer mode: two halves or sixteen words
// - alternate mode: A first, then B/A
// - clock source: RC when set, else system
// - auto-sample time in conversion clocks
// - divider gives period times value-plus-one
// - codes 0 to 12 route pins AN0-AN12
// - codes 13-15 pick internal references
// - code 31 reserved for charge-time unit
// - config bits disable internal reference channels
// - scan-select bits pick channels to scan
// - trigger source ends sampling
// - auto-sample restarts after each conversion
// - output format of 10-bit results
// - buffer lost when converter switched off
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "adsq_consts.vh"
module adsq_seq_ctrl (
  clk,
  rst_n,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  rc_tick,
  trig_pin,
  trig_tmr_a,
  trig_tmr_b,
  trig_ctu,
  conv_result,
  conv_done,
  sample_on,
  conv_start,
  tad_tick,
  pos_sel,
  pos_sel_valid,
  neg_sel_an1,
  ref_enables,
  pin_digital,
  conv_irq
);
  input wire clk;
  input wire rst_n;
  input wire [2:0] reg_addr;
  input wire [15:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [15:0] reg_rdata;
  input wire rc_tick;
  input wire trig_pin;
  input wire trig_tmr_a;
  input wire trig_tmr_b;
  input wire trig_ctu;
  input wire [9:0] conv_result;
  input wire conv_done;
  output reg sample_on;
  output reg conv_start;
  output wire tad_tick;
  output reg [4:0] pos_sel;
  output reg pos_sel_valid;
  output reg neg_sel_an1;
  output reg [2:0] ref_enables;
  output reg [12:0] pin_digital;
  output reg conv_irq;

  // ****************************************
  // reset and pin synchronisers
  // ****************************************
  reg [1:0] rst_sync_reg;
  wire srst_n;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign srst_n = rst_sync_reg[1];

  // rc tick and trigger pin come from outside this clock domain
  reg [2:0] rc_sync_reg;
  reg [2:0] pin_sync_reg;
  reg pin_level_reg;
  reg rc_level_reg;
  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      rc_sync_reg <= 3'b000;
      pin_sync_reg <= 3'b000;
      pin_level_reg <= 1'b0;
      rc_level_reg <= 1'b0;
    end else begin
      rc_sync_reg <= {rc_sync_reg[1:0], rc_tick};
      pin_sync_reg <= {pin_sync_reg[1:0], trig_pin};
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
        pin_level_reg <= pin_sync_reg[2];
      end
      if (rc_sync_reg[1] == rc_sync_reg[2]) begin
        rc_level_reg <= rc_sync_reg[2];
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  reg [15:0] ctrl1_reg;
  reg [15:0] ctrl2_reg;
  reg [15:0] ctrl3_reg;
  reg [15:0] insel_reg;
  reg [15:0] pin_analog_config_reg;
  reg [15:0] scan_reg;
  reg [3:0] buf_ix_reg;
  reg [9:0] buf_mem [0:15];

  wire conv_on = ctrl1_reg[`ADSQ_C1_ON];
  wire [1:0] fmt = ctrl1_reg[`ADSQ_C1_FMT_LO +: 2];
  wire [2:0] trig_src = ctrl1_reg[`ADSQ_C1_TRIG_LO +: 3];
  wire auto_sample_start = ctrl1_reg[`ADSQ_C1_AUTO_SAMPLE_START];
  wire scan_enable = ctrl2_reg[`ADSQ_C2_SCAN];
  wire [3:0] sequences_per_interrupt = ctrl2_reg[`ADSQ_C2_SEQUENCES_PER_INTERRUPT_LO +: 4];
  wire split_buffer_mode = ctrl2_reg[`ADSQ_C2_SPLIT_BUFFER_MODE];
  wire alternate_mux_mode = ctrl2_reg[`ADSQ_C2_ALTERNATE_MUX_MODE];
  wire [4:0] auto_sample_time = ctrl3_reg[`ADSQ_C3_AUTO_SAMPLE_TIME_LO +: 5];

  // ****************************************
  // conversion clock
  // ****************************************
  reg rc_prev_reg;
  wire rc_edge = rc_level_reg & ~rc_prev_reg;
  adsq_clkgen u_clkgen (
    .clk(clk),
    .rst_n(srst_n),
    .run(conv_on),
    .use_rc(ctrl3_reg[`ADSQ_C3_RC]),
    .rc_tick(rc_edge),
    .divider(ctrl3_reg[7:0]),
    .tad_tick(tad_tick)
  );

  // ****************************************
  // functions
  // ****************************************
  // same decode for both mux settings
  function code_ok;
    input [4:0] code;
    input [15:0] pin_analog_config;
    begin
      if (code <= `ADSQ_CH_LAST_PIN) begin
        code_ok = 1'b1;
      end else if (code == `ADSQ_CH_CORE) begin
        code_ok = ~pin_analog_config[13];
      end else if (code == `ADSQ_CH_HALF_BG) begin
        code_ok = ~pin_analog_config[14];
      end else if (code == `ADSQ_CH_BG) begin
        code_ok = ~pin_analog_config[15];
      end else begin
        code_ok = (code == `ADSQ_CH_CTU);
      end
    end
  endfunction

  // scan bit index to input code
  function [4:0] scan_code;
    input [3:0] idx;
    begin
      scan_code = {1'b0, idx};
    end
  endfunction

  function [15:0] format_word;
    input [9:0] d;
    input [1:0] f;
    begin
      case (f)
        2'b11: format_word = {~d[9], d[8:0], 6'h00};
        2'b10: format_word = {d, 6'h00};
        2'b01: format_word = {{7{~d[9]}}, d[8:0]};
        default: format_word = {6'h00, d};
      endcase
    end
  endfunction

  // ****************************************
  // sequence state machine
  // ****************************************
  localparam ST_IDLE = 3'b001;
  localparam ST_SAMPLE_ENABLE = 3'b010;
  localparam ST_CONV = 3'b100;
  reg [2:0] state_reg;
  reg [4:0] sample_enable_cnt_reg;
  reg use_b_reg;
  reg [3:0] scan_ix_reg;
  reg [3:0] wr_ptr_reg;
  reg [3:0] seq_cnt_reg;
  reg trig_pin_prev_reg;
  reg trig_hit;
  reg [3:0] nxt_ix;
  integer k;

  always @* begin
    case (trig_src)
      `ADSQ_TRIG_PIN: trig_hit = pin_level_reg & ~trig_pin_prev_reg;
      `ADSQ_TRIG_TMR_A: trig_hit = trig_tmr_a;
      `ADSQ_TRIG_TMR_B: trig_hit = trig_tmr_b;
      `ADSQ_TRIG_CTU: trig_hit = trig_ctu;
      `ADSQ_TRIG_AUTO: trig_hit = tad_tick &
        (sample_enable_cnt_reg + 5'h01 >= auto_sample_time);
      default: trig_hit = 1'b0;
    endcase
  end

  // a stopped converter restarts the scan at the lowest selected channel
  wire [3:0] scan_base = conv_on ? scan_ix_reg : 4'hF;

  // next enabled scan channel after the current one
  always @* begin
    nxt_ix = scan_base;
    for (k = 16; k >= 1; k = k - 1) begin
      if (scan_reg[scan_base + k[3:0]]) begin
        nxt_ix = scan_base + k[3:0];
      end
    end
  end

  always @* begin
    if (use_b_reg && alternate_mux_mode) begin
      pos_sel = insel_reg[12:8];
      neg_sel_an1 = insel_reg[15];
    end else if (scan_enable) begin
      pos_sel = scan_code(scan_ix_reg);
      neg_sel_an1 = insel_reg[7];
    end else begin
      pos_sel = insel_reg[4:0];
      neg_sel_an1 = insel_reg[7];
    end
    pos_sel_valid = conv_on & code_ok(pos_sel, pin_analog_config_reg);
    ref_enables = ~pin_analog_config_reg[15:13];
    pin_digital = pin_analog_config_reg[12:0];
  end

  wire sample_enable_bit = ctrl1_reg[`ADSQ_C1_SAMPLE_ENABLE];
  wire sw_end = (trig_src == `ADSQ_TRIG_SW) & reg_wr &
    (reg_addr == `ADSQ_ADDR_CTRL1) & ~reg_wdata[`ADSQ_C1_SAMPLE_ENABLE];
  wire half_size = split_buffer_mode;

  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      state_reg <= ST_IDLE;
      sample_enable_cnt_reg <= 5'h00;
      use_b_reg <= 1'b0;
      scan_ix_reg <= 4'h0;
      wr_ptr_reg <= 4'h0;
      seq_cnt_reg <= 4'h0;
      trig_pin_prev_reg <= 1'b0;
      rc_prev_reg <= 1'b0;
      ctrl1_reg <= 16'h0000;
      ctrl2_reg <= 16'h0000;
      ctrl3_reg <= 16'h0000;
      insel_reg <= 16'h0000;
      pin_analog_config_reg <= 16'h0000;
      scan_reg <= 16'h0000;
      buf_ix_reg <= 4'h0;
      sample_on <= 1'b0;
      conv_start <= 1'b0;
      conv_irq <= 1'b0;
    end else begin
      trig_pin_prev_reg <= pin_level_reg;
      rc_prev_reg <= rc_level_reg;
      conv_start <= 1'b0;
      conv_irq <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `ADSQ_ADDR_CTRL1: ctrl1_reg <= reg_wdata & `ADSQ_C1_WMASK;
          `ADSQ_ADDR_CTRL2: ctrl2_reg <= (reg_wdata & `ADSQ_C2_WMASK) |
            (ctrl2_reg & 16'h0080);
          `ADSQ_ADDR_CTRL3: ctrl3_reg <= reg_wdata & `ADSQ_C3_WMASK;
          `ADSQ_ADDR_INSEL: insel_reg <= reg_wdata & `ADSQ_INSEL_WMASK;
          `ADSQ_ADDR_PIN_ANALOG_CONFIG: pin_analog_config_reg <= reg_wdata;
          `ADSQ_ADDR_SCAN: scan_reg <= reg_wdata;
          `ADSQ_ADDR_BUFIX: buf_ix_reg <= reg_wdata[3:0];
          default: ;
        endcase
      end
      if (!conv_on) begin
        state_reg <= ST_IDLE;
        use_b_reg <= 1'b0;
        wr_ptr_reg <= 4'h0;
        seq_cnt_reg <= 4'h0;
        scan_ix_reg <= nxt_ix;
        ctrl2_reg[`ADSQ_C2_BUFFER_HALF_STATUS] <= 1'b0;
        sample_on <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (sample_enable_bit || auto_sample_start) begin
              state_reg <= ST_SAMPLE_ENABLE;
              sample_enable_cnt_reg <= 5'h00;
              sample_on <= 1'b1;
              ctrl1_reg[`ADSQ_C1_SAMPLE_ENABLE] <= 1'b1;
            end
          end
          ST_SAMPLE_ENABLE: begin
            if (tad_tick) begin
              sample_enable_cnt_reg <= sample_enable_cnt_reg + 5'h01;
            end
            if (trig_hit || sw_end) begin
              state_reg <= ST_CONV;
              sample_on <= 1'b0;
              conv_start <= 1'b1;
              ctrl1_reg[`ADSQ_C1_SAMPLE_ENABLE] <= 1'b0;
              ctrl1_reg[`ADSQ_C1_DONE] <= 1'b0;
            end
          end
          ST_CONV: begin
            if (conv_done) begin
              buf_mem[{half_size & ctrl2_reg[`ADSQ_C2_BUFFER_HALF_STATUS], 3'b000} |
                wr_ptr_reg] <= conv_result;
              ctrl1_reg[`ADSQ_C1_DONE] <= 1'b1;
              // a stale b phase must not outlive alternate mode
              use_b_reg <= alternate_mux_mode & ~use_b_reg;
              if (scan_enable && !use_b_reg) begin
                scan_ix_reg <= nxt_ix;
              end
              if (seq_cnt_reg == sequences_per_interrupt) begin
                seq_cnt_reg <= 4'h0;
                conv_irq <= 1'b1;
                wr_ptr_reg <= 4'h0;
                if (half_size) begin
                  ctrl2_reg[`ADSQ_C2_BUFFER_HALF_STATUS] <=
                    ~ctrl2_reg[`ADSQ_C2_BUFFER_HALF_STATUS];
                end
              end else begin
                seq_cnt_reg <= seq_cnt_reg + 4'h1;
                wr_ptr_reg <= half_size ? {1'b0, wr_ptr_reg[2:0] + 3'h1} :
                  wr_ptr_reg + 4'h1;
              end
              if (auto_sample_start) begin
                state_reg <= ST_SAMPLE_ENABLE;
                sample_enable_cnt_reg <= 5'h00;
                sample_on <= 1'b1;
                ctrl1_reg[`ADSQ_C1_SAMPLE_ENABLE] <= 1'b1;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADSQ_ADDR_CTRL1: reg_rdata <= ctrl1_reg;
        `ADSQ_ADDR_CTRL2: reg_rdata <= ctrl2_reg;
        `ADSQ_ADDR_CTRL3: reg_rdata <= ctrl3_reg;
        `ADSQ_ADDR_INSEL: reg_rdata <= insel_reg;
        `ADSQ_ADDR_PIN_ANALOG_CONFIG: reg_rdata <= pin_analog_config_reg;
        `ADSQ_ADDR_SCAN: reg_rdata <= scan_reg;
        // contents read as zero while off rather than cleared word by word
        `ADSQ_ADDR_BUFRD: reg_rdata <= conv_on ?
          format_word(buf_mem[buf_ix_reg], fmt) : 16'h0000;
        `ADSQ_ADDR_BUFIX: reg_rdata <= {12'h000, buf_ix_reg};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule // adsq_seq_ctrl

/* sim/adsq_analog_model.sv */
`timescale 1ns/100ps
module adsq_analog_model (
  input wire clk,
  input wire rst_n,
  input wire conv_start,
  input wire rc_run,
  output reg conv_done,
  output reg [9:0] conv_result,
  output reg rc_tick
);
  reg [4:0] busy;
  reg [2:0] rcc;
  reg [8:0] seq;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {busy, rcc, seq, conv_done, rc_tick} <= 19'h0;
      conv_result <= 10'h155;
    end else begin
      conv_done <= busy == 5'h01;
      busy <= conv_start ? 5'h14 : busy - {4'h0, busy != 5'h00};
      // result valid only beside done, toggles otherwise
      conv_result <= busy == 5'h01 ? {1'b1, seq} : ~conv_result;
      seq <= seq + (busy == 5'h01 ? 9'h025 : 9'h000);
      rcc <= rcc == 3'h4 ? 3'h0 : rcc + 3'h1;
      // the rc source stands still unless let run
      rc_tick <= rc_run && (rcc == 3'h4 ? ~rc_tick : rc_tick);
    end
  end
endmodule // adsq_analog_model

/* sim/adsq_seq_ctrl_props.sv */
`timescale 1ns/100ps
module adsq_seq_ctrl_props (
  input wire clk,
  input wire rst_n,
  input wire [2:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire trig_tmr_a,
  input wire sample_on,
  input wire conv_start,
  input wire tad_tick,
  input wire [4:0] pos_sel,
  input wire neg_sel_an1,
  input wire [2:0] ref_enables,
  input wire [12:0] pin_digital,
  input wire conv_irq
);
  reg [15:0] c3, ins, pc;
  reg [2:0] trig;
  reg scan_alt;
  reg [7:0] gap;
  wire [7:0] div = c3[7:0] > 8'h3F ? 8'h3F : c3[7:0];
  // shadows of written fields only, so hardware status bits cannot leak in
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {c3, ins, pc, trig, scan_alt} <= 52'h0;
      gap <= 8'hFF;
    end else begin
      if (reg_wr && reg_addr == 3'h0)
        trig <= reg_wdata[7:5];
      if (reg_wr && reg_addr == 3'h1)
        scan_alt <= reg_wdata[10] | reg_wdata[0];
      if (reg_wr && reg_addr == 3'h2)
        c3 <= reg_wdata;
      if (reg_wr && reg_addr == 3'h3)
        ins <= reg_wdata;
      if (reg_wr && reg_addr == 3'h4)
        pc <= reg_wdata;
      gap <= tad_tick ? 8'h01 : gap + {7'h00, gap != 8'hFF};
    end
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_ref_follow: assert property (
    reg_wr && reg_addr == 3'h4 |=> ref_enables == ~pc[15:13])
    else $error("reference enables wrong");
  a_pin_follow: assert property (
    reg_wr && reg_addr == 3'h4 |=> pin_digital == pc[12:0])
    else $error("pin mode wrong");
  a_mux_a_fixed: assert property (
    !scan_alt |-> pos_sel == ins[4:0])
    else $error("positive select wrong");
  a_neg_select: assert property (
    !scan_alt |-> neg_sel_an1 == ins[7])
    else $error("negative select wrong");
  a_start_pulse: assert property (
    conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_irq_pulse: assert property (
    conv_irq |=> !conv_irq)
    else $error("interrupt pulse too long");
  a_timer_ends: assert property (
    sample_on && trig_tmr_a && trig == 3'h2 |-> ##[1:3] conv_start)
    else $error("timer trigger ignored");
  a_tad_spacing: assert property (
    tad_tick && !c3[15] |-> gap > div)
    else $error("conversion clock too fast");
endmodule // adsq_seq_ctrl_props
bind adsq_seq_ctrl adsq_seq_ctrl_props i_props (.*);

/* sim/adsq_seq_ctrl_tb.sv */
`timescale 1ns/100ps
module adsq_seq_ctrl_tb;
  reg clk, rst_n, reg_wr, reg_rd, rc_run;
  reg trig_pin, trig_tmr_a, trig_tmr_b, trig_ctu;
  reg [2:0] reg_addr, n;
  reg [15:0] reg_wdata, fail_count, check_count, cyc;
  reg [15:0] starts, dones, irqs, ticks, s0, d0, i0;
  reg [4:0] pq [0:15];
  reg [9:0] rq [0:15];
  reg [9:0] d;
  wire [15:0] reg_rdata;
  wire [9:0] conv_result;
  wire [4:0] pos_sel;
  wire [2:0] ref_enables;
  wire [12:0] pin_digital;
  wire rc_tick, conv_done, sample_on, conv_start, tad_tick;
  wire pos_sel_valid, neg_sel_an1, conv_irq;
  integer i, j, k;
  adsq_seq_ctrl i_adsq_seq_ctrl (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_tick(rc_tick),
    .trig_pin(trig_pin), .trig_tmr_a(trig_tmr_a), .trig_tmr_b(trig_tmr_b),
    .trig_ctu(trig_ctu), .conv_result(conv_result), .conv_done(conv_done),
    .sample_on(sample_on), .conv_start(conv_start), .tad_tick(tad_tick),
    .pos_sel(pos_sel), .pos_sel_valid(pos_sel_valid),
    .neg_sel_an1(neg_sel_an1), .ref_enables(ref_enables),
    .pin_digital(pin_digital), .conv_irq(conv_irq));
  adsq_analog_model i_adsq_analog_model (.clk(clk), .rst_n(rst_n),
    .conv_start(conv_start), .rc_run(rc_run), .conv_done(conv_done),
    .conv_result(conv_result), .rc_tick(rc_tick));
  task wr(input [2:0] a, input [15:0] v);
    begin
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task chk(input [15:0] got, input [15:0] want);
    begin
      check_count = check_count + 16'h0001;
      if (got !== want) begin
        fail_count = fail_count + 16'h0001;
        $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
    end
  endtask
  // data stand one cycle only, so they are taken at the closing edge
  task rchk(input [2:0] a, input [15:0] want);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      chk(reg_rdata, want);
    end
  endtask
  task wdone(input [15:0] cnt);
    begin
      for (j = 0; j < 3000 && dones - d0 < cnt; j = j + 1)
        @(posedge clk);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 16'h0000 && check_count != 16'h0000)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 16'h0001;
    starts <= starts + {15'h0000, conv_start};
    dones <= dones + {15'h0000, conv_done};
    irqs <= irqs + {15'h0000, conv_irq};
    ticks <= ticks + {15'h0000, tad_tick};
    if (conv_start)
      pq[starts[3:0]] <= pos_sel;
    if (conv_done)
      rq[dones[3:0]] <= conv_result;
    if (cyc == 16'h2710) begin
      fail_count = fail_count + 16'h0001;
      summarize;
    end
  end
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, rc_run, trig_pin, trig_tmr_a, trig_tmr_b} = 6'h00;
    trig_ctu = 1'b0;
    {reg_addr, reg_wdata} = 19'h0;
    {fail_count, check_count, cyc, starts, dones, irqs, ticks} = 112'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 1; i < 6; i = i + 1) begin
      rchk(i[2:0], 16'h0000);
      wr(i[2:0], 16'hFFFF);
      rchk(i[2:0], i == 1 ? 16'hE43F : i == 2 ? 16'h9FFF :
        i == 3 ? 16'h9F9F : 16'hFFFF);
      wr(i[2:0], 16'h0000);
    end
    wr(3'h4, 16'h51C5);
    chk({ref_enables, pin_digital}, 16'hB1C5);
    for (i = 0; i < 17; i = i + 1) begin
      k = i == 16 ? 31 : i;
      wr(3'h3, {8'h00, i[0], 2'b00, k[4:0]});
      chk({10'h000, neg_sel_an1, pos_sel}, {10'h000, i[0], k[4:0]});
    end
    $display("test registers done");
    wr(3'h3, 16'h0000);
    wr(3'h2, 16'h0201);
    for (i = 0; i < 6; i = i + 1) begin
      n = i == 5 ? 3'h7 : i < 3 ? i[2:0] : i[2:0] + i[2:0] - 3'h2;
      d0 = dones;
      s0 = starts;
      wr(3'h0, {8'h80, n, 5'h02});
      repeat (20) @(posedge clk);
      if (n != 3'h7)
        chk(starts - s0, 16'h0000);
      trig_pin <= n == 3'h1;
      {trig_ctu, trig_tmr_b, trig_tmr_a} <= {n == 3'h6, n == 3'h4, n == 3'h2};
      if (n == 3'h0)
        wr(3'h0, 16'h8000);
      @(posedge clk);
      {trig_ctu, trig_tmr_b, trig_tmr_a} <= 3'h0;
      wdone(16'h0001);
      chk(starts - s0, 16'h0001);
      chk({15'h0000, sample_on}, 16'h0000);
      trig_pin <= 1'b0;
      wr(3'h0, 16'h0000);
    end
    $display("test triggers done");
    wr(3'h3, 16'h0503);
    wr(3'h1, 16'h001F);
    d0 = dones;
    s0 = starts;
    i0 = irqs;
    wr(3'h0, 16'h80E4);
    wdone(16'h0004);
    chk(irqs - i0, 16'h0000);
    rchk(3'h1, 16'h001F);
    wdone(16'h0008);
    repeat (3) @(posedge clk);
    chk(irqs - i0, 16'h0001);
    rchk(3'h1, 16'h009F);
    wr(3'h0, 16'h80E0);
    repeat (40) @(posedge clk);
    for (i = 0; i < 8; i = i + 1) begin
      chk({11'h000, pq[s0[3:0] + i[3:0]]}, i[0] ? 16'h0005 : 16'h0003);
      wr(3'h7, i[15:0]);
      rchk(3'h6, {6'h00, rq[d0[3:0] + i[3:0]]});
    end
    d = rq[d0[3:0]];
    for (i = 0; i < 4; i = i + 1) begin
      wr(3'h0, {6'h20, i[1:0], 8'hE0});
      wr(3'h7, 16'h0000);
      // signed forms flip the offset-binary msb into a sign
      rchk(3'h6, i == 3 ? {~d[9], d[8:0], 6'h00} : i == 2 ? {d, 6'h00} :
        i == 1 ? {{7{~d[9]}}, d[8:0]} : {6'h00, d});
    end
    wr(3'h0, 16'h0000);
    rchk(3'h6, 16'h0000);
    rchk(3'h1, 16'h001F);
    $display("test alternate done");
    wr(3'h5, 16'h2012);
    wr(3'h1, 16'h0400);
    wr(3'h3, 16'h0000);
    d0 = dones;
    s0 = starts;
    i0 = irqs;
    wr(3'h0, 16'h80E4);
    wdone(16'h0006);
    repeat (3) @(posedge clk);
    chk(irqs - i0, 16'h0006);
    wr(3'h0, 16'h0000);
    for (i = 0; i < 6; i = i + 1)
      chk({11'h000, pq[s0[3:0] + i[3:0]]}, i % 3 == 0 ? 16'h0001 :
        i % 3 == 1 ? 16'h0004 : 16'h000D);
    $display("test scan done");
    wr(3'h1, 16'h0000);
    wr(3'h2, 16'h8201);
    wr(3'h0, 16'h80E4);
    s0 = ticks;
    repeat (50) @(posedge clk);
    chk(ticks - s0, 16'h0000);
    for (i = 12; i < 18; i = i + 1) begin
      k = i == 17 ? 31 : i;
      wr(3'h3, k[15:0]);
      chk({15'h0000, pos_sel_valid},
        {15'h0000, k != 14 && k != 16});
    end
    rc_run <= 1'b1;
    repeat (100) @(posedge clk);
    chk({15'h0000, ticks != s0}, 16'h0001);
    $display("test clock source done");
    summarize;
  end
endmodule // adsq_seq_ctrl_tb
